// file: hw/ic_top.sv
// interrupt controller: flags, enables, vectoring, wake-up
// assumes a core on clk_sys giving instruction boundaries and
// stack-full status, peripherals giving one-cycle event pulses
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module ic_top #(
   parameter int PC_W = 13
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // sources
   input  wire logic [3:0]        ext_irq_pins,
   input  wire logic [3:0]        pin_fn_int,
   input  wire logic [3:0]        pin_dir_in,
   input  wire logic              conv_done_evt,
   input  wire logic [39:0]       grp_src_evt,
   // core
   input  wire logic              core_boundary,
   input  wire logic [PC_W-1:0]   core_next_pc,
   input  wire logic              core_stack_full,
   input  wire logic              core_ret,
   input  wire logic              core_sleep,
   output logic                   irq_take_q,
   output logic      [PC_W-1:0]   irq_vector_q,
   output logic      [PC_W-1:0]   irq_push_pc_q,
   output logic                   irq_pop_q,
   output logic                   wake_q,
   output logic      [3:0]        pull_high_q
);
   localparam int NE = ic_pkg::N_EXT;
   localparam int NG = ic_pkg::N_GRP;
   localparam int NM = ic_pkg::N_MEM;
   localparam int NS = ic_pkg::N_SRC;

   initial begin
      if (PC_W < 13) $error("ic_top: PC_W too narrow for vectors");
   end

   // ==========================================================
   // state
   logic                global_irq_enable_q;
   logic [NE-1:0]       ext_irq_flags_q;
   logic [NE-1:0]       ext_irq_enables_q;
   logic [2*NE-1:0]     ext_edge_select_reg_q;
   logic                conv_done_flag_q;
   logic                conv_done_enable_q;
   logic [NG-1:0]       group_request_flag_q;
   logic [NG-1:0]       group_enable_q;
   logic [NM-1:0]       mf_flag_q [NG];
   logic [NM-1:0]       mf_en_q   [NG];
   logic [NM-1:0]       mf_act_q  [NG];
   logic [3:0]          last_src_q;

   // ==========================================================
   // bus decode helpers
   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = {8{sel[b]}};
      end
      return m;
   endfunction

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      return adr[7:2] == off[7:2];
   endfunction

   logic        wr_go;
   logic [31:0] wmask;
   logic [31:0] wdat;
   // write lands on the edge where the master sees ack
   assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign wmask = byte_mask(wb_sel_i);
   assign wdat  = wb_dat_i & wmask;

   logic wr_gc, wr_ext, wr_conv, wr_grp;
   assign wr_gc   = wr_go & hit(wb_adr_i, ic_pkg::OFF_GCTRL);
   assign wr_ext  = wr_go & hit(wb_adr_i, ic_pkg::OFF_EXT);
   assign wr_conv = wr_go & hit(wb_adr_i, ic_pkg::OFF_CONV);
   assign wr_grp  = wr_go & hit(wb_adr_i, ic_pkg::OFF_GRP);

   // ==========================================================
   // external pins
   logic [NE-1:0] ext_set;
   genvar gi;
   generate
      for (gi = 0; gi < NE; gi++) begin : g_pin
         ic_pin_edge u_edge (
            .clk_sys  (clk_sys),
            .rst_n    (rst_n),
            .ce       (ce),
            .pin      (ext_irq_pins[gi]),
            .arm      (ext_irq_enables_q[gi] & pin_fn_int[gi] & pin_dir_in[gi]),
            .edge_sel (ext_edge_select_reg_q[2*gi +: 2]),
            .evt      (ext_set[gi])
         );
      end
   endgenerate

   // ==========================================================
   // priority and take decision
   logic [NS-1:0] pend;
   logic [NS-1:0] win_oh;
   logic [3:0]    win_idx;
   logic          win_vld;
   logic          take;
   logic [NS-1:0] svc_clr;

   // a flag with its enable low is held but never pending
   assign pend = {group_request_flag_q & group_enable_q,
                  conv_done_flag_q & conv_done_enable_q,
                  ext_irq_flags_q & ext_irq_enables_q};

   ic_prio #(.N(NS)) u_prio (
      .pend   (pend),
      .valid  (win_vld),
      .idx    (win_idx),
      .onehot (win_oh)
   );

   // no take back to back: gie is cleared by the first one anyway
   assign take = ce & win_vld & global_irq_enable_q
               & ~core_stack_full
               & core_boundary & ~irq_take_q;
   assign svc_clr = take ? win_oh : '0;

   // ==========================================================
   // global enable: software sets, service clears, set wins
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         global_irq_enable_q <= 1'b0;
      end else if (ce) begin
         if (wr_gc & wmask[ic_pkg::GC_GIE_BIT]) begin
            global_irq_enable_q <= wdat[ic_pkg::GC_GIE_BIT];
         end else if (take) begin
            global_irq_enable_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // external flags, enables, edge select, pull-high selection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_irq_flags_q       <= '0;
         ext_irq_enables_q     <= '0;
         ext_edge_select_reg_q <= '0;
         pull_high_q           <= '0;
      end else if (ce) begin
         if (wr_ext) begin
            ext_irq_enables_q <= (ext_irq_enables_q & ~wmask[ic_pkg::EXT_EN_LSB +: NE])
                               | wdat[ic_pkg::EXT_EN_LSB +: NE];
            ext_edge_select_reg_q <= (ext_edge_select_reg_q & ~wmask[ic_pkg::EXT_EDGE_LSB +: 2*NE])
                                   | wdat[ic_pkg::EXT_EDGE_LSB +: 2*NE];
            // pull-high stays whatever software chose, pin mode aside
            pull_high_q <= (pull_high_q & ~wmask[ic_pkg::EXT_PULL_LSB +: NE])
                         | wdat[ic_pkg::EXT_PULL_LSB +: NE];
            ext_irq_flags_q <= (((ext_irq_flags_q & ~wmask[ic_pkg::EXT_FLAG_LSB +: NE])
                              | wdat[ic_pkg::EXT_FLAG_LSB +: NE]) & ~svc_clr[NE-1:0])
                              | ext_set;
         end else begin
            // events latch even while gie is low
            ext_irq_flags_q <= (ext_irq_flags_q & ~svc_clr[NE-1:0]) | ext_set;
         end
      end
   end

   // ==========================================================
   // converter-done flag and enable
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         conv_done_flag_q   <= 1'b0;
         conv_done_enable_q <= 1'b0;
      end else if (ce) begin
         if (wr_conv & wmask[ic_pkg::CONV_EN_BIT]) begin
            conv_done_enable_q <= wdat[ic_pkg::CONV_EN_BIT];
         end
         if (conv_done_evt) begin
            conv_done_flag_q <= 1'b1;
         end else if (wr_conv & wmask[ic_pkg::CONV_FLAG_BIT]) begin
            conv_done_flag_q <= wdat[ic_pkg::CONV_FLAG_BIT];
         end else if (svc_clr[NE]) begin
            conv_done_flag_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // group member flags and enables, one 32-bit word per group
   logic [NG-1:0] grp_set;
   logic [NG-1:0] mf_rise;
   generate
      for (gi = 0; gi < NG; gi++) begin : g_grp
         localparam logic [3:0] IMPL = ic_pkg::MF_IMPL[4*gi +: 4];
         logic [7:0] off;
         logic       wr_mf;
         logic [3:0] set_m;
         logic [3:0] act;
         assign off   = ic_pkg::OFF_MF0 + 8'(4 * gi);
         assign wr_mf = wr_go & hit(wb_adr_i, off);
         // timer A/P matches arrive as member events
         assign set_m = grp_src_evt[4*gi +: 4] & IMPL;
         // source counts toward the group only with its own enable
         assign act   = mf_flag_q[gi] & mf_en_q[gi];
         assign grp_set[gi] = |(act & ~mf_act_q[gi]);
         assign mf_rise[gi] = |(set_m & ~mf_flag_q[gi]);

         // unimplemented slots never store, so they read zero
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               mf_flag_q[gi] <= '0;
               mf_en_q[gi]   <= '0;
               mf_act_q[gi]  <= '0;
            end else if (ce) begin
               mf_act_q[gi] <= act;
               if (wr_mf) begin
                  mf_en_q[gi] <= ((mf_en_q[gi] & ~wmask[ic_pkg::MF_EN_LSB +: 4])
                               | wdat[ic_pkg::MF_EN_LSB +: 4]) & IMPL;
                  mf_flag_q[gi] <= (((mf_flag_q[gi] & ~wmask[ic_pkg::MF_FLAG_LSB +: 4])
                                 | wdat[ic_pkg::MF_FLAG_LSB +: 4]) & IMPL) | set_m;
               end else begin
                  // service leaves member flags alone
                  mf_flag_q[gi] <= mf_flag_q[gi] | set_m;
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // group request flags and group enables
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         group_request_flag_q <= '0;
         group_enable_q       <= '0;
      end else if (ce) begin
         if (wr_grp) begin
            group_enable_q <= (group_enable_q & ~wmask[ic_pkg::GRP_EN_LSB +: NG])
                            | wdat[ic_pkg::GRP_EN_LSB +: NG];
            group_request_flag_q <= (((group_request_flag_q & ~wmask[ic_pkg::GRP_FLAG_LSB +: NG])
                                   | wdat[ic_pkg::GRP_FLAG_LSB +: NG]) & ~svc_clr[NS-1:NE+1])
                                   | grp_set;
         end else begin
            // only the group flag clears on service
            group_request_flag_q <= (group_request_flag_q & ~svc_clr[NS-1:NE+1]) | grp_set;
         end
      end
   end

   // ==========================================================
   // core side: vector, push, pop
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_take_q    <= 1'b0;
         irq_vector_q  <= '0;
         irq_push_pc_q <= '0;
         last_src_q    <= '0;
      end else if (ce) begin
         irq_take_q <= take;
         if (take) begin
            // next pc goes to the stack, vector goes to the pc
            irq_push_pc_q <= core_next_pc;
            irq_vector_q  <= PC_W'(ic_pkg::VEC_BASE + ic_pkg::VEC_STEP * 13'(win_idx));
            last_src_q    <= win_idx;
         end
      end
   end

   // return pops the saved pc; the core owns the stack itself
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_pop_q <= 1'b0;
      end else if (ce) begin
         irq_pop_q <= core_ret;
      end
   end

   // ==========================================================
   // wake: only a flag going 0->1; a flag preset by software
   // before sleep cannot rise again, so it does not wake
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else if (ce) begin
         wake_q <= core_sleep & (|(ext_set & ~ext_irq_flags_q)
                 | (conv_done_evt & ~conv_done_flag_q)
                 | |(grp_set & ~group_request_flag_q)
                 | |mf_rise);
      end
   end

   // ==========================================================
   // read mux and ack; unmapped reads return zero
   logic [31:0] rdat;
   always_comb begin
      rdat = ic_pkg::RST_ZERO;
      if (hit(wb_adr_i, ic_pkg::OFF_GCTRL)) begin
         rdat[ic_pkg::GC_GIE_BIT] = global_irq_enable_q;
         rdat[ic_pkg::GC_LAST_LSB +: 4] = last_src_q;
      end else if (hit(wb_adr_i, ic_pkg::OFF_EXT)) begin
         rdat[ic_pkg::EXT_FLAG_LSB +: NE]   = ext_irq_flags_q;
         rdat[ic_pkg::EXT_EN_LSB +: NE]     = ext_irq_enables_q;
         rdat[ic_pkg::EXT_EDGE_LSB +: 2*NE] = ext_edge_select_reg_q;
         rdat[ic_pkg::EXT_PULL_LSB +: NE]   = pull_high_q;
      end else if (hit(wb_adr_i, ic_pkg::OFF_CONV)) begin
         rdat[ic_pkg::CONV_FLAG_BIT] = conv_done_flag_q;
         rdat[ic_pkg::CONV_EN_BIT]   = conv_done_enable_q;
      end else if (hit(wb_adr_i, ic_pkg::OFF_GRP)) begin
         rdat[ic_pkg::GRP_FLAG_LSB +: NG] = group_request_flag_q;
         rdat[ic_pkg::GRP_EN_LSB +: NG]   = group_enable_q;
      end else begin
         for (int g = 0; g < NG; g++) begin
            if (hit(wb_adr_i, ic_pkg::OFF_MF0 + 8'(4 * g))) begin
               rdat[ic_pkg::MF_FLAG_LSB +: 4] = mf_flag_q[g];
               rdat[ic_pkg::MF_EN_LSB +: 4]   = mf_en_q[g];
            end
         end
      end
   end

   // one wait state; ack drops the cycle after it rose
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce) begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) ? rdat : ic_pkg::RST_ZERO;
      end
   end
endmodule // ic_top

// file: hw/ic_pkg.sv
// interrupt controller constants: register map, fields, vectors
// assumes a 32-bit classic wishbone slave, one word per register
package ic_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_GCTRL = 8'h00;
   localparam logic [7:0] OFF_EXT   = 8'h04;
   localparam logic [7:0] OFF_CONV  = 8'h08;
   localparam logic [7:0] OFF_GRP   = 8'h0c;
   localparam logic [7:0] OFF_MF0   = 8'h10; // group g at OFF_MF0 + 4*g
   // ==========================================================
   // field positions
   localparam int GC_GIE_BIT    = 0;
   localparam int GC_LAST_LSB   = 8;
   localparam int EXT_FLAG_LSB  = 0;
   localparam int EXT_EN_LSB    = 4;
   localparam int EXT_EDGE_LSB  = 8;
   localparam int EXT_PULL_LSB  = 16;
   localparam int CONV_FLAG_BIT = 0;
   localparam int CONV_EN_BIT   = 1;
   localparam int GRP_FLAG_LSB  = 0;
   localparam int GRP_EN_LSB    = 16;
   localparam int MF_FLAG_LSB   = 4;
   localparam int MF_EN_LSB     = 0;
   // ==========================================================
   // sizes, implemented member slots per group (group 9 top nibble)
   localparam int N_EXT = 4;
   localparam int N_GRP = 10;
   localparam int N_MEM = 4;
   localparam int N_SRC = 15;
   localparam logic [39:0] MF_IMPL = 40'h77373fb3ff;
   // ==========================================================
   // reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // ==========================================================
   // vectors: source index i jumps to VEC_BASE + VEC_STEP*i
   localparam logic [12:0] VEC_BASE = 13'h0004;
   localparam logic [12:0] VEC_STEP = 13'h0004;
   // ==========================================================
   // edge select encoding
   typedef enum logic [1:0] {
      IC_EDGE_OFF  = 2'b00,
      IC_EDGE_RISE = 2'b01,
      IC_EDGE_FALL = 2'b10,
      IC_EDGE_BOTH = 2'b11
   } ic_edge_t;
endpackage

// file: hw/ic_pin_edge.sv
// one external interrupt pin: synchroniser and edge detector
// assumes pin is asynchronous to clk_sys
`timescale 1ns/100ps
module ic_pin_edge (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       pin,
   input  wire logic       arm,
   input  wire logic [1:0] edge_sel,
   output logic            evt
);
   logic s1_q, s2_q, s3_q;
   ic_pkg::ic_edge_t sel;
   // ==========================================================
   // two-flop sync, third flop for edge compare
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // ==========================================================
   // edge choice; off kills the input entirely
   always_comb begin
      sel = ic_pkg::ic_edge_t'(edge_sel);
      unique case (sel)
         ic_pkg::IC_EDGE_OFF:  evt = 1'b0;
         ic_pkg::IC_EDGE_RISE: evt = arm & s2_q & ~s3_q;
         ic_pkg::IC_EDGE_FALL: evt = arm & ~s2_q & s3_q;
         ic_pkg::IC_EDGE_BOTH: evt = arm & (s2_q ^ s3_q);
      endcase
   end
endmodule // ic_pin_edge

// file: hw/ic_prio.sv
// fixed priority pick: lowest index wins
// assumes pending vector from the same clock
`timescale 1ns/100ps
module ic_prio #(
   parameter int N = 15
) (
   input  wire logic [N-1:0]         pend,
   output logic                      valid,
   output logic [$clog2(N)-1:0]      idx,
   output logic [N-1:0]              onehot
);
   initial begin
      if (N < 2) $error("ic_prio: N must be at least 2");
   end
   // ==========================================================
   // scan from the top so index 0 overrides last
   always_comb begin
      valid  = 1'b0;
      idx    = '0;
      onehot = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            valid  = 1'b1;
            idx    = ($clog2(N))'(i);
            onehot = '0;
            onehot[i] = 1'b1;
         end
      end
   end
endmodule // ic_prio

// file: dv/ic_top_sva.sv
// checker for ic_top: bus answer, vectoring, stack, wake-up
// assumes one clock domain and is bound to every ic_top
`timescale 1ns/100ps
module ic_top_sva #(
   parameter int PC_W = 13
) (
   input wire logic            clk_sys,
   input wire logic            rst_n,
   input wire logic            wb_cyc_i,
   input wire logic            wb_stb_i,
   input wire logic            wb_we_i,
   input wire logic [7:0]      wb_adr_i,
   input wire logic [31:0]     wb_dat_o,
   input wire logic            wb_ack_o,
   input wire logic [PC_W-1:0] core_next_pc,
   input wire logic            core_stack_full,
   input wire logic            core_ret,
   input wire logic            core_sleep,
   input wire logic            irq_take_q,
   input wire logic [PC_W-1:0] irq_vector_q,
   input wire logic [PC_W-1:0] irq_push_pc_q,
   input wire logic            irq_pop_q,
   input wire logic            wake_q
);
   // ==========================================================
   // properties, all on clk_sys
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h38 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   stack_block_a: assert property (core_stack_full |=> !irq_take_q) else $error("take on full stack");
   push_pc_a: assert property (irq_take_q |-> irq_push_pc_q == $past(core_next_pc)) else $error("bad push");
   vec_range_a: assert property (irq_take_q |-> irq_vector_q[1:0] == 2'b00 &&
      irq_vector_q >= ic_pkg::VEC_BASE && irq_vector_q <= 13'h3c) else $error("bad vector");
   vec_hold_a: assert property (!irq_take_q |-> $stable(irq_vector_q)) else $error("vector moved");
   take_gap_a: assert property (irq_take_q |=> !irq_take_q [*2]) else $error("takes too close");
   pop_follow_a: assert property (core_ret |=> irq_pop_q) else $error("no pop");
   pop_cause_a: assert property (irq_pop_q |-> $past(core_ret)) else $error("stray pop");
   wake_cause_a: assert property (!core_sleep [*2] |=> !wake_q) else $error("wake while awake");
endmodule // ic_top_sva
bind ic_top ic_top_sva #(.PC_W(PC_W)) i_sva (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .core_next_pc(core_next_pc), .core_stack_full(core_stack_full), .core_ret(core_ret),
   .core_sleep(core_sleep), .irq_take_q(irq_take_q), .irq_vector_q(irq_vector_q),
   .irq_push_pc_q(irq_push_pc_q), .irq_pop_q(irq_pop_q), .wake_q(wake_q));

// file: dv/ic_core_model.sv
// processor core model: pc, eight-deep stack, sleep and return
// assumes the controller's take and pop pulses on clk_sys
`timescale 1ns/100ps
module ic_core_model #(
   parameter int PC_W = 13
) (
   input  wire logic            clk_sys,
   input  wire logic            rst_n,
   input  wire logic            irq_take_q,
   input  wire logic [PC_W-1:0] irq_vector_q,
   input  wire logic [PC_W-1:0] irq_push_pc_q,
   input  wire logic            irq_pop_q,
   input  wire logic            full_req,
   input  wire logic            ret_req,
   input  wire logic            sleep_req,
   output logic                 core_boundary,
   output logic      [PC_W-1:0] core_next_pc,
   output logic                 core_stack_full,
   output logic                 core_ret,
   output logic                 core_sleep,
   output logic      [PC_W-1:0] pc_q
);
   logic [PC_W-1:0] stack_q [0:7];
   logic [3:0]      sp_q;
   // ==========================================================
   // one instruction a cycle; full_req stands for deep nesting
   assign core_boundary   = 1'b1;
   assign core_next_pc    = pc_q + 1'b1;
   assign core_stack_full = full_req || sp_q == 4'h8;
   assign core_ret        = ret_req && sp_q != 4'h0;
   assign core_sleep      = sleep_req;
   // push on take, pop on return; pc frozen while asleep
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= '0;
         sp_q <= 4'h0;
      end else if (irq_take_q) begin
         stack_q[sp_q[2:0]] <= irq_push_pc_q;
         sp_q <= sp_q + 4'h1;
         pc_q <= irq_vector_q;
      end else if (irq_pop_q) begin
         sp_q <= sp_q - 4'h1;
         pc_q <= stack_q[sp_q[2:0] - 3'h1];
      end else if (!sleep_req) begin
         pc_q <= core_next_pc;
      end
   end
endmodule // ic_core_model

// file: dv/testbench.sv
// self-checking bench for ic_top with a core model
// assumes ic_pkg offsets and the hand-over timing
`timescale 1ns/100ps
module testbench;
   logic        clk_sys, rst_n, cyc, stb, we, ack, conv, take, pop, wake, bnd, full, ret, slp;
   logic        full_req, ret_req, sleep_req;
   logic [7:0]  adr;
   logic [3:0]  sel, pins, fn, dir, pull;
   logic [31:0] wdat, rdat, take_vec;
   logic [39:0] grp;
   logic [12:0] npc, vec, push, pc;
   int          error_cnt, n_compared, n_take, n_pop, n_wake, cyc_n;
   ic_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pins(pins),
      .pin_fn_int(fn), .pin_dir_in(dir), .conv_done_evt(conv), .grp_src_evt(grp), .core_boundary(bnd),
      .core_next_pc(npc), .core_stack_full(full), .core_ret(ret), .core_sleep(slp), .irq_take_q(take),
      .irq_vector_q(vec), .irq_push_pc_q(push), .irq_pop_q(pop), .wake_q(wake), .pull_high_q(pull));
   ic_core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .irq_take_q(take), .irq_vector_q(vec),
      .irq_push_pc_q(push), .irq_pop_q(pop), .full_req(full_req), .ret_req(ret_req), .sleep_req(sleep_req),
      .core_boundary(bnd), .core_next_pc(npc), .core_stack_full(full), .core_ret(ret), .core_sleep(slp),
      .pc_q(pc));
   // ==========================================================
   // clock, event counters and hang limit
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (take === 1'b1) begin
         n_take++;
         take_vec <= 32'(vec);
      end
      if (pop === 1'b1) n_pop++;
      if (wake === 1'b1) n_wake++;
      cyc_n++;
      if (cyc_n == 5000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic single cycle: hold until ack, then drop
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
      // no local limit: only the bench hang counter ends this wait
      do begin
         @(posedge clk_sys);
      end while (ack !== 1'b1);
      r = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      rchk(ic_pkg::OFF_GCTRL, 32'h0);
      wr(8'h34, 32'hff);
      rchk(8'h34, 32'h77);
      wr(8'h30, 32'hff);
      rchk(8'h30, 32'h77);
      rchk(ic_pkg::OFF_GRP, 32'h300);
      wr(8'h3c, 32'hff);
      rchk(8'h3c, 32'h0);
      wr(8'h30, 32'h0);
      wr(8'h34, 32'h0);
      wr(ic_pkg::OFF_GRP, 32'h0);
      $display("regs done");
   endtask
   task automatic t_conv();
      conv <= 1'b1;
      idle(1);
      conv <= 1'b0;
      rchk(ic_pkg::OFF_CONV, 32'h1);
      wr(ic_pkg::OFF_GCTRL, 32'h1);
      idle(4);
      chk(n_take, 0);
      wr(ic_pkg::OFF_CONV, 32'h3);
      idle(4);
      chk(n_take, 1);
      chk(take_vec, 32'h14);
      rchk(ic_pkg::OFF_CONV, 32'h2);
      rchk(ic_pkg::OFF_GCTRL, 32'h400);
      ret_req <= 1'b1;
      idle(1);
      ret_req <= 1'b0;
      idle(3);
      chk(n_pop, 1);
      $display("conv done");
   endtask
   task automatic t_ext();
      logic [31:0] d;
      for (int m = 0; m < 4; m++) begin
         d = {12'h0, 4'ha, 6'h0, 2'(m), 8'h10};
         wr(ic_pkg::OFF_EXT, d);
         pins <= 4'h1;
         idle(5);
         rchk(ic_pkg::OFF_EXT, d | 32'(m & 1));
         wr(ic_pkg::OFF_EXT, d);
         pins <= 4'h0;
         idle(5);
         rchk(ic_pkg::OFF_EXT, d | 32'(m >> 1));
      end
      chk({28'h0, pull}, 32'ha);
      wr(ic_pkg::OFF_GCTRL, 32'h1);
      idle(4);
      chk(take_vec, 32'h4);
      rchk(ic_pkg::OFF_EXT, d);
      dir <= 4'h0;
      pins <= 4'h1;
      idle(5);
      pins <= 4'h0;
      idle(5);
      rchk(ic_pkg::OFF_EXT, d);
      dir <= 4'hf;
      $display("ext done");
   endtask
   task automatic t_group();
      wr(8'h34, 32'h1);
      grp <= 40'h10_0000_0000;
      idle(1);
      grp <= 40'h0;
      rchk(ic_pkg::OFF_GRP, 32'h200);
      full_req <= 1'b1;
      wr(ic_pkg::OFF_GRP, 32'h0200_0200);
      wr(ic_pkg::OFF_GCTRL, 32'h1);
      idle(4);
      chk(n_take, 2);
      full_req <= 1'b0;
      idle(4);
      chk(take_vec, 32'h3c);
      rchk(ic_pkg::OFF_GRP, 32'h0200_0000);
      rchk(8'h34, 32'h11);
      wr(8'h34, 32'h1);
      $display("group done");
   endtask
   task automatic t_wake();
      sleep_req <= 1'b1;
      conv <= 1'b1;
      idle(1);
      conv <= 1'b0;
      idle(4);
      chk(n_wake, 1);
      conv <= 1'b1;
      idle(1);
      conv <= 1'b0;
      idle(4);
      chk(n_wake, 1);
      sleep_req <= 1'b0;
      $display("wake done");
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      {rst_n, cyc, stb, we, conv, full_req, ret_req, sleep_req} = '0;
      {adr, sel, wdat, grp, pins} = '0;
      {fn, dir} = 8'hff;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_conv();
      t_ext();
      t_group();
      t_wake();
      complete_run();
   end
endmodule // testbench
